//--- smc_consts.vh
// smc_consts.vh: constants of the management-mode control block
// assumes: included by the design files of this block only
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
`define SMC_RESUME_OP0      8'h0F
`define SMC_RESUME_OP1      8'hAA
`define SMC_FLAGS_INIT      32'h00000002
`define SMC_DBGCTL_INIT     32'h00000400
`define SMC_IP_INIT         32'h00008000
`define SMC_BASE_INIT       32'h00030000
`define SMC_CS_SEL_INIT     16'h3000
`define SMC_CW_CLR_MASK     32'h8000000D
`define SMC_BIT_PROT        0
`define SMC_BIT_NWT         29
`define SMC_BIT_CDIS        30
`define SMC_BIT_PAGE        31
`define SMC_ALIGN_MASK      32'h00007FFF
`define SMC_SAVE_TOP        32'h0000FFFF
`define SMC_SAVE_BOT        32'h0000FE00
`define SMC_IORST_YES       8'hFF
`define SMC_IORST_NO        8'h00
`define SMC_LIMIT_SMM       32'hFFFFFFFF
`define SMC_LIMIT_REAL      32'h0000FFFF
`define SMC_SAVE_WORDS      8'h80
`endif

//--- smc_seg_calc.v
// smc_seg_calc.v: real-mode style segment base from a loaded selector
// assumes: selector load pulses come from the decode stage
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_seg_calc (
  input  wire        clk,
  input  wire        rst,
  input  wire        segLoad,
  input  wire [15:0] segSel,
  input  wire        mgmtMode,
  output reg  [31:0] segBase_r
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      segBase_r <= 32'h00000000;
    end else if (segLoad && mgmtMode) begin
      segBase_r <= {12'h000, segSel, 4'h0}; // RULE_22
    end
  end
endmodule // smc_seg_calc

//--- smc_state_check.v
// smc_state_check.v: validity check of the restored state on resume
// assumes: inputs are the values read back from the save area
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_state_check (
  input  wire [31:0] dumpBase,
  input  wire [31:0] ctrlWord,
  output wire        stateBad
);
  wire baseBad;
  wire cwBad;
  assign baseBad  = |(dumpBase & `SMC_ALIGN_MASK); // RULE_04
  assign cwBad    = (ctrlWord[`SMC_BIT_PAGE] & ~ctrlWord[`SMC_BIT_PROT]) |
                    (ctrlWord[`SMC_BIT_NWT] &
                     ~ctrlWord[`SMC_BIT_CDIS]); // RULE_05
  assign stateBad = baseBad | cwBad;
endmodule // smc_state_check

//--- smc_mgmt_ctrl.v
// smc_mgmt_ctrl.v: management-mode entry and exit control
// assumes: instruction boundary, opcode and restored values come from core
//
// How it works
// (RULE_01) enter only on management request; leave on resume or reset
// (RULE_02) opcode 0F AA decodes as the resume instruction
// (RULE_03) resume outside management mode raises invalid opcode
// (RULE_04) shutdown if restored dump base is not 32 Kbyte aligned
// (RULE_05) shutdown if paging without protection, or no write-through uncached; the code checks no write-through with cache enabled
// (RULE_06) shutdown issues a bus cycle and halts until NMI or reset
// (RULE_07) halt interrupted: re-enter halt unless halt-restart slot cleared
// (RULE_08) I/O-restart slot set: re-execute trapped I/O instruction
// (RULE_09) base register reloads from relocation slot on resume
// (RULE_10) reset forces exit from management mode
// (RULE_11) after recognition wait until all stores and buffers drained
// (RULE_12) chipset ends final write with transfer-done or burst done
// (RULE_13) after drain assert active, save state, then fetch handler
// (RULE_14) management request wins over debug and external interrupt
// (RULE_15) only first request in management mode is latched for later
// (RULE_16) entry clears control word bits 0, 2, 3 and 31
// (RULE_17) entry loads flags 00000002 and debug control 00000400
// (RULE_18) entry disables maskable and non-maskable interrupts
// (RULE_19) handler starts at offset 8000 with code base default 30000
// (RULE_20) code selector 3000 kept; other selectors and bases zero
// (RULE_21) management mode uses 4 Gbyte limit and 16-bit defaults
// (RULE_22) selector load sets base to selector shifted left four
// (RULE_23) arbitration and bus-sizing inputs keep working in this mode
// (RULE_24) save area walks down from top, then jump to handler
// (RULE_25) I/O slot FF re-executes, 00 not; slot set 00 on entry
// (RULE_26) active output held until restore done, dropped before normal bus
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_mgmt_ctrl (
  input  wire        clk,
  input  wire        rst,
  input  wire        mgmtIntRequest,
  input  wire        instrBoundary,
  input  wire        debugExcReq,
  input  wire        extIntReq,
  input  wire        nmiReq,
  input  wire        opValid,
  input  wire [7:0]  opByte0,
  input  wire [7:0]  opByte1,
  input  wire        writesPending,
  input  wire        transferDone,
  input  wire        burstTransferDoneInput,
  input  wire        saveWordDone,
  input  wire        haltState,
  input  wire        ioTrapped,
  input  wire [31:0] ctrlWordIn,
  input  wire        restoreDone,
  input  wire [31:0] rstCtrlWord,
  input  wire [31:0] rstDumpBase,
  input  wire        rstHaltSlot,
  input  wire [7:0]  rstIoSlot,
  input  wire        segLoad,
  input  wire [15:0] segSel,
  input  wire        busHoldIn,
  input  wire        addressHoldInput,
  input  wire        backOffInput,
  input  wire        busSize8Input,
  input  wire        busSize16Input,
  output reg         mgmtActiveOutput_r,
  output reg         managementMode_r,
  output reg         invalidOpcode_r,
  output reg         shutdownCycle_r,
  output reg         shutdown_r,
  output reg         saveWrite_r,
  output reg  [31:0] saveAddr_r,
  output reg         restoreRead_r,
  output reg         fetchStart_r,
  output reg  [31:0] fetchAddr_r,
  output reg  [31:0] ctrlWordOut_r,
  output reg  [31:0] flagsOut_r,
  output reg  [31:0] dbgCtlOut_r,
  output reg  [15:0] csSel_r,
  output reg  [31:0] csBase_r,
  output reg  [31:0] dataSegBase_r,
  output reg  [31:0] managementBase_r,
  output reg         intEnable_r,
  output reg         nmiEnable_r,
  output reg  [31:0] segLimit_r,
  output reg         size16_r,
  output reg         restartHalt_r,
  output reg         restartIo_r,
  output reg  [7:0]  ioSlotInit_r,
  output reg         haltSlotInit_r,
  output reg         debugTake_r,
  output reg         extIntTake_r,
  output reg         busArbPass_r,
  output reg  [1:0]  busSizePass_r
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'd0;
  localparam [2:0] ST_DRAIN = 3'd1;
  localparam [2:0] ST_SAVE  = 3'd2;
  localparam [2:0] ST_HDLR  = 3'd3;
  localparam [2:0] ST_REST  = 3'd4;
  localparam [2:0] ST_SHUT  = 3'd5;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg         pendReq_r;
  reg         haltAtEntry_r;
  reg         ioAtEntry_r;
  reg  [7:0]  saveCnt_r;
  reg         wasPending_r;
  reg         segLoadD_r;
  wire        stateBad;
  wire        isResume;
  wire        takeReq;
  wire        lastWriteDone;
  wire [31:0] calcBase;

  assign isResume = opValid && (opByte0 == `SMC_RESUME_OP0) &&
                    (opByte1 == `SMC_RESUME_OP1); // RULE_02
  assign takeReq  = instrBoundary && (mgmtIntRequest || pendReq_r) &&
                    (state_r == ST_RUN); // RULE_01 RULE_14
  // buffers empty, and the last write ended by a done strobe if one ran
  assign lastWriteDone = !writesPending &&
                         (!wasPending_r || transferDone ||
                          burstTransferDoneInput); // RULE_11 RULE_12

  smc_state_check uChk (
    .dumpBase (rstDumpBase),
    .ctrlWord (rstCtrlWord),
    .stateBad (stateBad)
  );

  smc_seg_calc uSeg (
    .clk       (clk),
    .rst       (rst),
    .segLoad   (segLoad),
    .segSel    (segSel),
    .mgmtMode  (managementMode_r),
    .segBase_r (calcBase)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:   if (takeReq) state_nxt = ST_DRAIN;
      ST_DRAIN: if (lastWriteDone) state_nxt = ST_SAVE; // RULE_11
      ST_SAVE:  if (saveWordDone && saveCnt_r == `SMC_SAVE_WORDS - 8'h01)
                  state_nxt = ST_HDLR; // RULE_13
      ST_HDLR:  if (isResume) state_nxt = ST_REST;
      ST_REST:  if (restoreDone)
                  state_nxt = stateBad ? ST_SHUT : ST_RUN; // RULE_04 RULE_05
      ST_SHUT:  if (nmiReq) state_nxt = ST_RUN; // RULE_06
      default:  state_nxt = ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin // RULE_10
      state_r            <= ST_RUN;
      pendReq_r          <= 1'b0;
      haltAtEntry_r      <= 1'b0;
      ioAtEntry_r        <= 1'b0;
      saveCnt_r          <= 8'h00;
      wasPending_r       <= 1'b0;
      segLoadD_r         <= 1'b0;
      mgmtActiveOutput_r <= 1'b0;
      managementMode_r   <= 1'b0;
      invalidOpcode_r    <= 1'b0;
      shutdownCycle_r    <= 1'b0;
      shutdown_r         <= 1'b0;
      saveWrite_r        <= 1'b0;
      saveAddr_r         <= 32'h00000000;
      restoreRead_r      <= 1'b0;
      fetchStart_r       <= 1'b0;
      fetchAddr_r        <= 32'h00000000;
      ctrlWordOut_r      <= 32'h00000000;
      flagsOut_r         <= `SMC_FLAGS_INIT;
      dbgCtlOut_r        <= `SMC_DBGCTL_INIT;
      csSel_r            <= 16'h0000;
      csBase_r           <= 32'h00000000;
      dataSegBase_r      <= 32'h00000000;
      managementBase_r   <= `SMC_BASE_INIT;
      intEnable_r        <= 1'b1;
      nmiEnable_r        <= 1'b1;
      segLimit_r         <= `SMC_LIMIT_REAL;
      size16_r           <= 1'b0;
      restartHalt_r      <= 1'b0;
      restartIo_r        <= 1'b0;
      ioSlotInit_r       <= `SMC_IORST_NO;
      haltSlotInit_r     <= 1'b0;
      debugTake_r        <= 1'b0;
      extIntTake_r       <= 1'b0;
      busArbPass_r       <= 1'b0;
      busSizePass_r      <= 2'b00;
    end else begin
      state_r         <= state_nxt;
      invalidOpcode_r <= isResume && !managementMode_r; // RULE_03
      shutdownCycle_r <= 1'b0;
      saveWrite_r     <= 1'b0;
      restoreRead_r   <= 1'b0;
      fetchStart_r    <= 1'b0;
      restartHalt_r   <= 1'b0;
      restartIo_r     <= 1'b0;
      // request wins the boundary; the others only when none is taken
      debugTake_r  <= instrBoundary && debugExcReq && !takeReq &&
                      !managementMode_r; // RULE_14
      extIntTake_r <= instrBoundary && extIntReq && !takeReq &&
                      intEnable_r && state_r == ST_RUN; // RULE_14
      busArbPass_r  <= busHoldIn | addressHoldInput | backOffInput; // RULE_23
      busSizePass_r <= {busSize16Input, busSize8Input}; // RULE_23
      wasPending_r  <= writesPending; // RULE_11
      // the computed base lands one cycle after the selector load
      segLoadD_r    <= segLoad && managementMode_r;
      if (segLoadD_r)
        dataSegBase_r <= calcBase; // RULE_22
      // one request latched while in the mode, the rest dropped
      if (takeReq)
        pendReq_r <= 1'b0;
      else if (managementMode_r && mgmtIntRequest)
        pendReq_r <= 1'b1; // RULE_15
      case (state_r)
        ST_RUN: begin
          if (takeReq) begin
            haltAtEntry_r <= haltState;
            ioAtEntry_r   <= ioTrapped;
          end
        end
        ST_DRAIN: begin
          if (lastWriteDone) begin
            mgmtActiveOutput_r <= 1'b1; // RULE_13 RULE_26
            managementMode_r   <= 1'b1;
            ctrlWordOut_r  <= ctrlWordIn & ~`SMC_CW_CLR_MASK; // RULE_16
            flagsOut_r     <= `SMC_FLAGS_INIT; // RULE_17
            dbgCtlOut_r    <= `SMC_DBGCTL_INIT; // RULE_17
            intEnable_r    <= 1'b0; // RULE_18
            nmiEnable_r    <= 1'b0; // RULE_18
            csSel_r        <= `SMC_CS_SEL_INIT; // RULE_20
            csBase_r       <= managementBase_r; // RULE_19
            dataSegBase_r  <= 32'h00000000; // RULE_20
            segLimit_r     <= `SMC_LIMIT_SMM; // RULE_21
            size16_r       <= 1'b1; // RULE_21
            ioSlotInit_r   <= `SMC_IORST_NO; // RULE_25
            haltSlotInit_r <= haltAtEntry_r; // RULE_07
            saveCnt_r      <= 8'h00;
            saveAddr_r     <= managementBase_r + `SMC_SAVE_TOP; // RULE_24
          end
        end
        ST_SAVE: begin
          saveWrite_r <= 1'b1;
          if (saveWordDone) begin
            saveCnt_r  <= saveCnt_r + 8'h01;
            saveAddr_r <= saveAddr_r - 32'h00000004; // RULE_24
            if (saveCnt_r == `SMC_SAVE_WORDS - 8'h01) begin
              saveWrite_r  <= 1'b0;
              fetchStart_r <= 1'b1; // RULE_13
              fetchAddr_r  <= managementBase_r + `SMC_IP_INIT; // RULE_19
            end
          end
        end
        ST_HDLR: begin
          if (isResume)
            restoreRead_r <= 1'b1;
        end
        ST_REST: begin
          restoreRead_r <= !restoreDone;
          if (restoreDone) begin
            mgmtActiveOutput_r <= 1'b0; // RULE_26
            managementMode_r   <= 1'b0; // RULE_01
            intEnable_r        <= 1'b1;
            nmiEnable_r        <= 1'b1;
            segLimit_r         <= `SMC_LIMIT_REAL;
            size16_r           <= 1'b0;
            ctrlWordOut_r      <= rstCtrlWord;
            if (stateBad) begin
              shutdown_r      <= 1'b1; // RULE_06
              shutdownCycle_r <= 1'b1; // RULE_06
            end else begin
              managementBase_r <= rstDumpBase; // RULE_09
              restartHalt_r    <= haltAtEntry_r && rstHaltSlot; // RULE_07
              restartIo_r      <= ioAtEntry_r &&
                                  (rstIoSlot == `SMC_IORST_YES); // RULE_08 RULE_25
            end
          end
        end
        ST_SHUT: begin
          if (nmiReq)
            shutdown_r <= 1'b0; // RULE_06
        end
        default: begin
          shutdown_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // smc_mgmt_ctrl

//--- smc_chipset_model.sv
// smc_chipset_model.sv: chipset side of the management-mode control
// assumes: driven by clk and rst of the bench, answers the save/restore
`timescale 1ns/1ps
module smc_chipset_model (
  input  wire       clk, rst, mgmtIntRequest, mgmtActiveOutput_r,
  input  wire       saveWrite_r, restoreRead_r,
  input  wire [3:0] drainLen,
  output wire       writesPending,
  output reg        transferDone, burstTransferDoneInput,
  output reg        saveWordDone, restoreDone
);
  // ---------------------------------------------------------------
  // store drain, save acknowledge, restore completion
  // ---------------------------------------------------------------
  reg [3:0] wCnt_r;
  reg [2:0] rCnt_r;
  reg       armed_r, pick_r;
  assign writesPending = (wCnt_r != 4'h0);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {wCnt_r, rCnt_r, armed_r, pick_r} <= 9'h000;
      {transferDone, burstTransferDoneInput} <= 2'h0;
      {saveWordDone, restoreDone} <= 2'h0;
    end else begin
      {transferDone, burstTransferDoneInput, restoreDone} <= 3'h0;
      if (mgmtIntRequest && !armed_r && !mgmtActiveOutput_r) begin
        wCnt_r <= drainLen;
        armed_r <= 1'b1;
      end else if (wCnt_r != 4'h0) begin
        wCnt_r <= wCnt_r - 4'h1;
        if (wCnt_r == 4'h1) begin
          transferDone <= ~pick_r;
          burstTransferDoneInput <= pick_r;
          pick_r <= ~pick_r;
        end
      end
      if (mgmtActiveOutput_r)
        armed_r <= 1'b0;
      // every other cycle, so the save stalls
      saveWordDone <= saveWrite_r && !saveWordDone;
      if (!restoreRead_r)
        rCnt_r <= 3'h0;
      else if (rCnt_r != 3'h7) begin
        rCnt_r <= rCnt_r + 3'h1;
        restoreDone <= (rCnt_r == 3'h5);
      end
    end
  end
endmodule // smc_chipset_model

//--- smc_mgmt_ctrl_chk.sv
// smc_mgmt_ctrl_chk.sv: port assertions of the management-mode control
// assumes: bound to smc_mgmt_ctrl, one clock, async reset rst
`timescale 1ns/1ps
module smc_mgmt_ctrl_chk (
  input wire        clk, rst, mgmtActiveOutput_r, managementMode_r,
  input wire        writesPending, intEnable_r, nmiEnable_r, fetchStart_r,
  input wire        opValid, invalidOpcode_r, restoreDone, restoreRead_r,
  input wire        shutdown_r, instrBoundary, mgmtIntRequest,
  input wire        debugTake_r, extIntTake_r,
  input wire [7:0]  ioSlotInit_r, opByte0, opByte1,
  input wire [15:0] csSel_r,
  input wire [31:0] flagsOut_r, dbgCtlOut_r, csBase_r, managementBase_r,
  input wire [31:0] dataSegBase_r, segLimit_r, ctrlWordOut_r, ctrlWordIn,
  input wire [31:0] fetchAddr_r, rstDumpBase, rstCtrlWord
);
  // ---------------------------------------------------------------
  // entry, exit and restore checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_drain;
    $rose(mgmtActiveOutput_r) |-> !$past(writesPending);
  endproperty
  a_drain: assert property (p_drain)
    else $error("active output before writes drained");
  property p_init;
    $rose(mgmtActiveOutput_r) |-> flagsOut_r == 32'h00000002 &&
      dbgCtlOut_r == 32'h00000400 && !intEnable_r && !nmiEnable_r &&
      ioSlotInit_r == 8'h00;
  endproperty
  a_init: assert property (p_init)
    else $error("entry values of flags or enables wrong");
  property p_seg;
    $rose(mgmtActiveOutput_r) |-> csSel_r == 16'h3000 &&
      csBase_r == managementBase_r && dataSegBase_r == 32'h00000000 &&
      segLimit_r == 32'hFFFFFFFF &&
      ctrlWordOut_r == (ctrlWordIn & 32'h7FFFFFF2);
  endproperty
  a_seg: assert property (p_seg)
    else $error("entry segment or control word wrong");
  property p_fetch;
    fetchStart_r |-> mgmtActiveOutput_r &&
      fetchAddr_r == managementBase_r + 32'h00008000;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("handler fetch address wrong");
  property p_invop;
    opValid && opByte0 == 8'h0F && opByte1 == 8'hAA |=>
      invalidOpcode_r == !$past(managementMode_r);
  endproperty
  a_invop: assert property (p_invop)
    else $error("resume opcode fault wrong");
  property p_exit;
    restoreDone && restoreRead_r |=>
      !mgmtActiveOutput_r && !managementMode_r;
  endproperty
  a_exit: assert property (p_exit)
    else $error("active output kept after restore");
  property p_shut;
    restoreDone && restoreRead_r && (rstDumpBase[14:0] != 15'h0000 ||
      rstCtrlWord[31] && !rstCtrlWord[0] ||
      rstCtrlWord[29] && !rstCtrlWord[30]) |=> shutdown_r;
  endproperty
  a_shut: assert property (p_shut)
    else $error("bad restored state without shutdown");
  property p_prio;
    instrBoundary && mgmtIntRequest && !managementMode_r &&
      !mgmtActiveOutput_r && !shutdown_r |=> !debugTake_r && !extIntTake_r;
  endproperty
  a_prio: assert property (p_prio)
    else $error("debug or interrupt taken with request");
endmodule // smc_mgmt_ctrl_chk

//--- smc_mgmt_ctrl_tb.sv
// smc_mgmt_ctrl_tb.sv: self-checking bench of the management-mode control
// assumes: smc_chipset_model as far side, smc_mgmt_ctrl_chk bound below
`timescale 1ns/1ps
module smc_mgmt_ctrl_tb;
  logic        clk = '0, rst = 1'b1, mgmtIntRequest = '0, instrBoundary = '0;
  logic        debugExcReq = '0, extIntReq = '0, nmiReq = '0, opValid = '0;
  logic        haltState = '0, ioTrapped = '0, rstHaltSlot = '0;
  logic        segLoad = '0;
  logic [7:0]  opByte0 = '0, opByte1 = '0, rstIoSlot = '0;
  logic [15:0] segSel = '0;
  logic [31:0] ctrlWordIn = 32'h6000001F, rstCtrlWord = '0, rstDumpBase = '0;
  logic [4:0]  busPat = '0, prevPat = '0;
  logic [3:0]  drainLen = 4'h3;
  logic [31:0] badB [3] = '{32'h00030100, 32'h00030000, 32'h00030000};
  logic [31:0] badW [3] = '{32'h00000011, 32'h80000010, 32'h20000011};
  wire         writesPending, transferDone, burstTransferDoneInput;
  wire         saveWordDone, restoreDone, busHoldIn, addressHoldInput;
  wire         backOffInput, busSize8Input, busSize16Input;
  wire         mgmtActiveOutput_r, managementMode_r, invalidOpcode_r;
  wire         shutdownCycle_r, shutdown_r, saveWrite_r, restoreRead_r;
  wire         fetchStart_r, intEnable_r, nmiEnable_r, size16_r;
  wire         restartHalt_r, restartIo_r, haltSlotInit_r, debugTake_r;
  wire         extIntTake_r, busArbPass_r;
  wire [1:0]   busSizePass_r;
  wire [7:0]   ioSlotInit_r;
  wire [15:0]  csSel_r;
  wire [31:0]  saveAddr_r, fetchAddr_r, ctrlWordOut_r, flagsOut_r;
  wire [31:0]  dbgCtlOut_r, csBase_r, dataSegBase_r, managementBase_r;
  wire [31:0]  segLimit_r;
  int compares = 0, failCount = 0, nInv = 0, nHalt = 0, nIo = 0, nCyc = 0;
  int nFetch = 0, nSave = 0, goal = 0;
  assign {busSize16Input, busSize8Input, backOffInput} = busPat[4:2];
  assign {addressHoldInput, busHoldIn} = busPat[1:0];
  smc_mgmt_ctrl dut (.*);
  smc_chipset_model chipset (.*);
  // ---------------------------------------------------------------
  // clock, pulse counters, helpers
  // ---------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    busPat <= busPat + 5'h01;
    prevPat <= busPat;
    nInv <= nInv + invalidOpcode_r;
    nHalt <= nHalt + restartHalt_r;
    nIo <= nIo + restartIo_r;
    nCyc <= nCyc + shutdownCycle_r;
    nFetch <= nFetch + fetchStart_r;
    nSave <= nSave + saveWordDone;
  end
  task printVerdict();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic sig(input int w);
    if (w == 0) return mgmtActiveOutput_r;
    if (w == 1) return shutdown_r;
    return nFetch == goal;
  endfunction
  task waitFor(input int w, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && sig(w) !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    chk("wait done", 0, i >= lim);
    if (i >= lim) printVerdict();
  endtask
  task enter(input logic req, input logic [31:0] b);
    int s;
    @(posedge clk);
    {mgmtIntRequest, instrBoundary, debugExcReq, extIntReq} <= {req, 3'h7};
    @(posedge clk);
    {mgmtIntRequest, instrBoundary, debugExcReq, extIntReq} <= 4'h0;
    #1;
    chk("takes", 0, {debugTake_r, extIntTake_r});
    s = nSave;
    goal = nFetch + 1;
    waitFor(0, 1'b1, 40);
    chk("saveTop", b + 32'h0000FFFF, saveAddr_r);
    chk("size16", 1, size16_r);
    chk("busArb", |prevPat[2:0], busArbPass_r);
    chk("cword", 32'h60000012, ctrlWordOut_r);
    chk("csSel", 32'h3000, csSel_r);
    chk("csBase", b, csBase_r);
    chk("limit", 32'hFFFFFFFF, segLimit_r);
    chk("haltSlot", haltState, haltSlotInit_r);
    waitFor(2, 1'b1, 600);
    chk("fetch", b + 32'h00008000, fetchAddr_r);
    chk("saves", 128, nSave - s);
    chk("saveEnd", b + 32'h0000FDFF, saveAddr_r);
    @(posedge clk);
    {segLoad, segSel} <= {1'b1, 16'h1234};
    @(posedge clk);
    segLoad <= 1'b0;
    @(posedge clk);
    #1;
    chk("dsBase", 32'h00012340, dataSegBase_r);
  endtask
  task resume(input logic [31:0] b, w, input logic h, input logic [7:0] io);
    {rstDumpBase, rstCtrlWord, rstHaltSlot, rstIoSlot} <= {b, w, h, io};
    @(posedge clk);
    {opValid, opByte0, opByte1} <= {1'b1, 8'h0F, 8'hAA};
    @(posedge clk);
    opValid <= 1'b0;
    #1;
    waitFor(0, 1'b0, 60);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task pulseReset();
    @(posedge clk);
    rst <= 1'b1;
    #1;
    chk("mode", 0, {managementMode_r, mgmtActiveOutput_r});
    @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("flags", 32'h00000002, flagsOut_r);
    chk("dbg", 32'h00000400, dbgCtlOut_r);
    chk("mBase", 32'h00030000, managementBase_r);
    chk("enables", 3, {intEnable_r, nmiEnable_r});
    repeat (24) begin
      @(posedge clk);
      #1;
      chk("busArb", |prevPat[2:0], busArbPass_r);
      chk("busSize", prevPat[4:3], busSizePass_r);
    end
    resume(32'h00030000, 32'h00000011, 1'b0, 8'h00);
    chk("invOp", 1, nInv);
    {haltState, ioTrapped} <= 2'h3;
    enter(1'b1, 32'h00030000);
    repeat (2) begin
      @(posedge clk);
      mgmtIntRequest <= 1'b1;
      @(posedge clk);
      mgmtIntRequest <= 1'b0;
    end
    resume(32'h00048000, 32'h00000011, 1'b1, 8'hFF);
    chk("invOp", 1, nInv);
    chk("haltRst", 1, nHalt);
    chk("ioRst", 1, nIo);
    chk("mBase", 32'h00048000, managementBase_r);
    enter(1'b0, 32'h00048000);
    resume(32'h00030000, 32'h00000011, 1'b0, 8'h00);
    chk("haltRst", 1, nHalt);
    chk("ioRst", 1, nIo);
    @(posedge clk);
    {instrBoundary, debugExcReq, extIntReq} <= 3'h7;
    @(posedge clk);
    {instrBoundary, debugExcReq, extIntReq} <= 3'h0;
    #1;
    chk("takes", 3, {debugTake_r, extIntTake_r});
    repeat (5) @(posedge clk);
    #1;
    chk("active", 0, mgmtActiveOutput_r);
    {haltState, ioTrapped} <= 2'h0;
    for (int k = 0; k < 3; k++) begin
      enter(1'b1, 32'h00030000);
      resume(badB[k], badW[k], 1'b0, 8'h00);
      chk("shutdown", 1, shutdown_r);
      chk("shutCycles", k + 1, nCyc);
      @(posedge clk);
      nmiReq <= 1'b1;
      @(posedge clk);
      nmiReq <= 1'b0;
      waitFor(1, 1'b0, 20);
      pulseReset();
    end
    enter(1'b1, 32'h00030000);
    pulseReset();
    printVerdict();
  end
endmodule // smc_mgmt_ctrl_tb
bind smc_mgmt_ctrl smc_mgmt_ctrl_chk chk (.*);
